// File: core/pcs_pkg.sv
// Package holding the constants and types of the 16-bit card strobe controller.
package pcs_pkg;

   // ----------------------------------------------------------------
   // Cycle kinds requested by the host side
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PCS_OP_MEM_RD,
      PCS_OP_MEM_WR,
      PCS_OP_IO_RD,
      PCS_OP_IO_WR
   } pcs_op_t;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   // Least strobe width in ns; rounded up to whole cycles below.
   localparam int STROBE_MIN_NS = 80;
   localparam int STROBE_CYCLES = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Setup from address and enables to the strobe.
   localparam int SETUP_MIN_NS = 24;
   localparam int SETUP_CYCLES = (SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYCLES);
   localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(SETUP_CYCLES);

   // ----------------------------------------------------------------
   // Reset values of the card-side pins (strobes inactive high)
   // ----------------------------------------------------------------
   localparam logic STROBE_IDLE = 1'b1;

endpackage

// File: core/pcs_sync.sv
// Two-flop synchroniser for the card inputs.
module pcs_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] async_in,
   input wire logic [W-1:0] rst_val,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   // Both flops reset to all ones; rst_val drops out of the output term, so it has no effect.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q & (rst_val | ~rst_val);
endmodule

// File: core/pcs_ctrl.sv
// Strobe sequencer for one 16-bit card socket.
//
// Contract
// - The low-byte enable selects even bytes and the high-byte enable selects odd bytes.
// - The I/O read strobe is asserted during host I/O read cycles.
// - The I/O write strobe is driven low during host I/O write cycles.
// - Output enable is driven low during host memory read cycles.
// - The shared status line is ready only in memory-only mode, otherwise the interrupt request.
// - Attribute select stays high for common memory and is asserted for attribute and I/O.
// - A cycle's completion is held off while the card asserts wait.
module pcs_ctrl (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic mem_only_mode,
   input wire logic req_valid,
   input wire pcs_pkg::pcs_op_t req_op,
   input wire logic req_attr,
   input wire logic req_addr0,
   input wire logic req_wide,
   input wire logic [15:0] req_wdata,
   output logic req_ready,
   output logic rsp_valid,
   output logic [15:0] rsp_rdata,
   output logic rsp_no_ack,
   output logic card_enable_low_byte_n,
   output logic card_enable_high_byte_n,
   output logic output_enable_n,
   output logic write_enable_n,
   output logic io_read_strobe_n,
   output logic io_write_strobe_n,
   output logic attr_select_n,
   output logic [15:0] data_out,
   output logic data_oe,
   input wire logic [15:0] data_in,
   input wire logic input_acknowledge_n,
   input wire logic ready_irq_n,
   input wire logic wait_n,
   output logic card_ready,
   output logic card_interrupt_request
);
   import pcs_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [2:0] sync_v;
   logic input_acknowledge_s;
   logic rdy_s;
   logic wait_s;

   pcs_sync #(.W(3)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in({input_acknowledge_n, ready_irq_n, wait_n}),
      .rst_val(3'h7),
      .sync_out(sync_v)
   );

   always_comb begin
      input_acknowledge_s = ~sync_v[2];
      rdy_s = sync_v[1];
      wait_s = ~sync_v[0];
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {PCS_IDLE, PCS_SETUP, PCS_STROBE, PCS_DONE} pcs_state_t;

   pcs_state_t state_q, state_d;
   pcs_op_t op_q, op_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic attr_q, attr_d;
   logic ce_lo_q, ce_lo_d;
   logic ce_hi_q, ce_hi_d;
   logic [15:0] wdata_q, wdata_d;
   logic [15:0] rdata_q, rdata_d;
   logic ack_q, ack_d;
   logic rsp_q, rsp_d;
   logic rdy_q, rdy_d;
   logic irq_q, irq_d;
   logic can_start;
   logic is_mem;

   function automatic logic op_is_mem(input pcs_op_t op);
      return (op == PCS_OP_MEM_RD) || (op == PCS_OP_MEM_WR);
   endfunction

   always_comb begin
      is_mem = op_is_mem(req_op);
      // A busy memory card must not see a new command.
      can_start = !(is_mem && mem_only_mode && !rdy_s);
   end

   always_comb begin
      state_d = state_q;
      op_d = op_q;
      cnt_d = cnt_q;
      attr_d = attr_q;
      ce_lo_d = ce_lo_q;
      ce_hi_d = ce_hi_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      ack_d = ack_q;
      rsp_d = 1'b0;
      // Ready and interrupt share one pin; the mode picks the meaning.
      rdy_d = mem_only_mode & rdy_s;
      irq_d = ~mem_only_mode & ~rdy_s;
      case (state_q)
         PCS_IDLE: begin
            if (req_valid && can_start) begin
               op_d = req_op;
               // Attribute select only for attribute memory or I/O space.
               attr_d = req_attr || !op_is_mem(req_op);
               // Even byte on the low enable, odd byte on the high enable.
               ce_lo_d = req_wide || !req_addr0;
               ce_hi_d = req_wide || req_addr0;
               wdata_d = req_wdata;
               ack_d = 1'b0;
               cnt_d = SETUP_CNT;
               state_d = PCS_SETUP;
            end
         end
         PCS_SETUP: begin
            if (cnt_q > CNT_W'(1)) begin
               cnt_d = cnt_q - CNT_W'(1);
            end else begin
               cnt_d = STROBE_CNT;
               state_d = PCS_STROBE;
            end
         end
         PCS_STROBE: begin
            if (op_q == PCS_OP_IO_RD && input_acknowledge_s) begin
               ack_d = 1'b1;
            end
            if (cnt_q > CNT_W'(1)) begin
               cnt_d = cnt_q - CNT_W'(1);
            end else if (!wait_s) begin
               rdata_d = data_in;
               rsp_d = 1'b1;
               state_d = PCS_DONE;
            end
         end
         PCS_DONE: begin
            ce_lo_d = 1'b0;
            ce_hi_d = 1'b0;
            attr_d = 1'b0;
            state_d = PCS_IDLE;
         end
         default: begin
            state_d = PCS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= PCS_IDLE;
         op_q <= PCS_OP_MEM_RD;
         cnt_q <= '0;
         attr_q <= 1'b0;
         ce_lo_q <= 1'b0;
         ce_hi_q <= 1'b0;
         wdata_q <= 16'h0000;
         rdata_q <= 16'h0000;
         ack_q <= 1'b0;
         rsp_q <= 1'b0;
         rdy_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         cnt_q <= cnt_d;
         attr_q <= attr_d;
         ce_lo_q <= ce_lo_d;
         ce_hi_q <= ce_hi_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         ack_q <= ack_d;
         rsp_q <= rsp_d;
         rdy_q <= rdy_d;
         irq_q <= irq_d;
      end
   end

   // ----------------------------------------------------------------
   // Pin registers
   // ----------------------------------------------------------------
   logic oe_n_q, oe_n_d;
   logic we_n_q, we_n_d;
   logic io_read_strobe_n_q, io_read_strobe_n_d;
   logic io_write_strobe_n_q, io_write_strobe_n_d;
   logic dout_en_q, dout_en_d;
   logic in_cycle;
   logic ce_lo_n_q, ce_lo_n_d, ce_hi_n_q, ce_hi_n_d, attr_n_q, attr_n_d;
   logic idle_q, idle_d, no_ack_q, no_ack_d;

   always_comb begin
      in_cycle = (state_d == PCS_STROBE);
      oe_n_d = !(in_cycle && op_d == PCS_OP_MEM_RD);
      we_n_d = !(in_cycle && op_d == PCS_OP_MEM_WR);
      io_read_strobe_n_d = !(in_cycle && op_d == PCS_OP_IO_RD);
      io_write_strobe_n_d = !(in_cycle && op_d == PCS_OP_IO_WR);
      // Write data is driven from setup through strobe so it is stable at the edge.
      dout_en_d = (state_d == PCS_SETUP || state_d == PCS_STROBE)
                  && (op_d == PCS_OP_MEM_WR || op_d == PCS_OP_IO_WR);
      ce_lo_n_d = !ce_lo_d;
      ce_hi_n_d = !ce_hi_d;
      attr_n_d = !attr_d;
      idle_d = (state_d == PCS_IDLE);
      no_ack_d = rsp_d && op_d == PCS_OP_IO_RD && !ack_d;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         oe_n_q <= STROBE_IDLE;
         we_n_q <= STROBE_IDLE;
         io_read_strobe_n_q <= STROBE_IDLE;
         io_write_strobe_n_q <= STROBE_IDLE;
         dout_en_q <= 1'b0;
         ce_lo_n_q <= STROBE_IDLE;
         ce_hi_n_q <= STROBE_IDLE;
         attr_n_q <= STROBE_IDLE;
         idle_q <= 1'b1;
         no_ack_q <= 1'b0;
      end else begin
         oe_n_q <= oe_n_d;
         we_n_q <= we_n_d;
         io_read_strobe_n_q <= io_read_strobe_n_d;
         io_write_strobe_n_q <= io_write_strobe_n_d;
         dout_en_q <= dout_en_d;
         ce_lo_n_q <= ce_lo_n_d;
         ce_hi_n_q <= ce_hi_n_d;
         attr_n_q <= attr_n_d;
         idle_q <= idle_d;
         no_ack_q <= no_ack_d;
      end
   end

   assign card_enable_low_byte_n = ce_lo_n_q;
   assign card_enable_high_byte_n = ce_hi_n_q;
   assign attr_select_n = attr_n_q;
   assign output_enable_n = oe_n_q;
   assign write_enable_n = we_n_q;
   assign io_read_strobe_n = io_read_strobe_n_q;
   assign io_write_strobe_n = io_write_strobe_n_q;
   assign data_out = wdata_q;
   assign data_oe = dout_en_q;
   assign req_ready = idle_q;
   assign rsp_valid = rsp_q;
   assign rsp_rdata = rdata_q;
   assign rsp_no_ack = no_ack_q;
   assign card_ready = rdy_q;
   assign card_interrupt_request = irq_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_strobe_one_hot: assert property (
      $onehot0({~oe_n_q, ~we_n_q, ~io_read_strobe_n_q, ~io_write_strobe_n_q}))
      else $error("More than one strobe active.");
   a_io_read_strobe_enable: assert property (!io_read_strobe_n_q |-> (ce_lo_q || ce_hi_q) && attr_q)
      else $error("I/O read without enable or attribute select.");
   a_io_write_strobe_data: assert property (!io_write_strobe_n_q |-> dout_en_q && attr_q)
      else $error("I/O write strobe without driven data.");
   a_oe_common: assert property (!oe_n_q |-> dout_en_q == 1'b0)
      else $error("Output enable while driving data.");
   a_byte_lane: assert property ($rose(state_q == PCS_SETUP) && !$past(req_wide)
      |-> ce_lo_q == !$past(req_addr0) && ce_hi_q == $past(req_addr0))
      else $error("Byte enable does not match address bit.");
   a_mode_share: assert property (!$past(sys_rst, 3) |->
      card_ready == ($past(mem_only_mode) && $past(ready_irq_n, 3))
      && card_interrupt_request == (!$past(mem_only_mode) && !$past(ready_irq_n, 3)))
      else $error("Status line meaning does not follow the mode.");
   a_busy_hold: assert property (state_q == PCS_IDLE && req_valid && mem_only_mode
      && op_is_mem(req_op) && !rdy_s |=> state_q == PCS_IDLE)
      else $error("Memory command started while card busy.");
   a_attr_common: assert property ($rose(state_q == PCS_SETUP) && op_is_mem(op_q)
      && !$past(req_attr) |-> !attr_q)
      else $error("Attribute select on common memory.");
   a_wait_hold: assert property (state_q == PCS_STROBE && cnt_q <= CNT_W'(1) && wait_s
      |=> !rsp_q)
      else $error("Cycle completed while wait asserted.");
   c_io_read: cover property (!io_read_strobe_n_q ##[1:40] rsp_q);
   c_mem_write: cover property (!we_n_q ##[1:40] rsp_q);
   c_wait_ext: cover property (state_q == PCS_STROBE && wait_s ##[1:20] rsp_q);
endmodule

// File: verif/pcs_card_model.sv
// Behavioural model of an inserted 16-bit memory or I/O card.
module pcs_card_model (
   input wire logic clk,
   input wire logic mem_only_mode,
   input wire logic busy,
   input wire logic irq,
   input wire logic ack_en,
   input wire logic [3:0] wait_len,
   input wire logic output_enable_n,
   input wire logic write_enable_n,
   input wire logic io_read_strobe_n,
   input wire logic io_write_strobe_n,
   input wire logic [15:0] data_out,
   output logic [15:0] data_in,
   output logic input_acknowledge_n,
   output logic ready_irq_n,
   output logic wait_n
);
   logic [15:0] mem_q = 16'h0000;
   logic [15:0] io_q = 16'h0000;
   logic [4:0] cnt_q = 5'h00;
   wire rd = !output_enable_n || !io_read_strobe_n;
   wire st = rd || !write_enable_n || !io_write_strobe_n;
   // Memory and I/O space keep separate words, so an I/O write never spoils a memory read.
   always @(posedge write_enable_n) mem_q <= data_out;
   always @(posedge io_write_strobe_n) io_q <= data_out;
   always @(posedge clk) cnt_q <= st ? cnt_q + 5'h01 : 5'h00;
   assign wait_n = !(st && cnt_q < {1'b0, wait_len});
   // A released bus shows the inverse so that a stale value never matches.
   assign data_in = !output_enable_n ? mem_q : !io_read_strobe_n ? io_q : ~mem_q;
   assign input_acknowledge_n = !(ack_en && !io_read_strobe_n);
   assign ready_irq_n = mem_only_mode ? !busy : !irq;
endmodule

// File: verif/tb_pc_card_16bit_control_strobes.sv
// Self-checking bench for the card strobe sequencer.
module tb_pc_card_16bit_control_strobes;
   timeunit 1ns;
   timeprecision 1ps;
   import pcs_pkg::*;
   typedef struct {pcs_op_t op; logic at, a0, wd, ak; logic [3:0] wt; logic [15:0] d;
      logic [2:0] en;} pcs_row_t;
   logic clk = 1'b0, sys_rst = 1'b1, mem_only_mode = 1'b1, req_valid = 1'b0;
   logic req_attr = 1'b0, req_addr0 = 1'b0, req_wide = 1'b0;
   logic busy = 1'b0, irq = 1'b0, ack_en = 1'b0;
   logic [3:0] wait_len = 4'h0;
   pcs_op_t req_op = PCS_OP_MEM_RD;
   logic [15:0] req_wdata = 16'h0000, rsp_rdata, data_out, data_in;
   logic req_ready, rsp_valid, rsp_no_ack, card_enable_low_byte_n, card_enable_high_byte_n;
   logic output_enable_n, write_enable_n, io_read_strobe_n, io_write_strobe_n, attr_select_n;
   logic data_oe, input_acknowledge_n, ready_irq_n, wait_n, card_ready, card_interrupt_request;
   int bad_count = 0, n_compared = 0;
   // Columns: kind, attr, addr0, wide, ack, wait, data, expected {low, high, attr}.
   pcs_row_t rows [7] = '{
      '{PCS_OP_MEM_WR, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 16'h1234, 3'b011},
      '{PCS_OP_MEM_RD, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 16'h1234, 3'b011},
      '{PCS_OP_MEM_WR, 1'b1, 1'b1, 1'b0, 1'b1, 4'h0, 16'hA55A, 3'b100},
      '{PCS_OP_MEM_RD, 1'b1, 1'b1, 1'b1, 1'b1, 4'hE, 16'hA55A, 3'b000},
      '{PCS_OP_IO_WR, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 16'h0F0F, 3'b000},
      '{PCS_OP_IO_RD, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 16'h0F0F, 3'b100},
      '{PCS_OP_IO_RD, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0F0F, 3'b010}};
   always #4 clk = ~clk;
   pcs_ctrl dut_u (.clk, .sys_rst, .mem_only_mode, .req_valid, .req_op, .req_attr, .req_addr0,
      .req_wide, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .rsp_no_ack,
      .card_enable_low_byte_n, .card_enable_high_byte_n, .output_enable_n, .write_enable_n,
      .io_read_strobe_n, .io_write_strobe_n, .attr_select_n, .data_out, .data_oe, .data_in,
      .input_acknowledge_n, .ready_irq_n, .wait_n, .card_ready, .card_interrupt_request);
   pcs_card_model card_u (.clk, .mem_only_mode, .busy, .irq, .ack_en, .wait_len,
      .output_enable_n, .write_enable_n, .io_read_strobe_n, .io_write_strobe_n, .data_out,
      .data_in, .input_acknowledge_n, .ready_irq_n, .wait_n);
   // ----------------------------------------------------------------
   // Compare and closing tasks
   // ----------------------------------------------------------------
   task automatic chk1(logic got, logic exp, string m);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic chk16(logic [15:0] got, logic [15:0] exp, string m);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic complete_run;
      $display("compared %0d, wrong %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // One cycle; the request is held until the enables show it was taken
   // ----------------------------------------------------------------
   task automatic run(pcs_row_t r, int hold);
      logic [3:0] seen;
      logic [2:0] en;
      int n, lo, dr;
      seen = 4'h0;
      en = 3'b111;
      n = 0;
      lo = 0;
      dr = 0;
      repeat (2) @(posedge clk);
      #1;
      ack_en = r.ak;
      wait_len = r.wt;
      req_op = r.op;
      req_attr = r.at;
      req_addr0 = r.a0;
      req_wide = r.wd;
      req_wdata = r.d;
      req_valid = 1'b1;
      while (card_enable_low_byte_n && card_enable_high_byte_n && n < 100) begin
         @(posedge clk);
         #1;
         n++;
         if (n == hold) busy = 1'b0;
      end
      req_valid = 1'b0;
      chk1(n > hold, 1'b1, "started while card busy");
      chk1(req_ready, 1'b0, "ready while cycle runs");
      n = 0;
      while (rsp_valid !== 1'b1 && n < 200) begin
         seen |= ~{output_enable_n, write_enable_n, io_read_strobe_n, io_write_strobe_n};
         en &= {card_enable_low_byte_n, card_enable_high_byte_n, attr_select_n};
         if (!(output_enable_n && write_enable_n && io_read_strobe_n && io_write_strobe_n))
            lo++;
         if (data_oe) dr++;
         @(posedge clk);
         #1;
         n++;
      end
      chk1(rsp_valid, 1'b1, "no completion");
      chk16({12'h000, seen}, 16'h0008 >> r.op, "strobe kind");
      chk16({13'h0000, en}, {13'h0000, r.en}, "enables or attr");
      chk1(r.wt == 0 ? lo == STROBE_CYCLES : lo >= r.wt, 1'b1, "strobe width");
      chk1(dr == (r.op[0] ? SETUP_CYCLES + lo : 0), 1'b1, "data drive window");
      if (r.op == PCS_OP_IO_RD) chk1(rsp_no_ack, !r.ak, "acknowledge flag");
      if (!r.op[0] && r.ak) chk16(rsp_rdata, r.d, "read data");
      $display("test done: kind %0d", r.op);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      #1;
      chk1(output_enable_n && write_enable_n && io_read_strobe_n && io_write_strobe_n,
         1'b1, "strobes in reset");
      chk1(req_ready && !data_oe && card_enable_low_byte_n, 1'b1, "idle in reset");
      sys_rst = 1'b0;
      foreach (rows[i]) run(rows[i], 0);
      busy = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk1(card_ready, 1'b0, "ready flag while busy");
      run(rows[3], 20);
      chk1(card_ready, 1'b1, "ready flag");
      mem_only_mode = 1'b0;
      irq = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk1(card_interrupt_request && !card_ready, 1'b1, "interrupt flag");
      run(rows[3], 0);
      irq = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk1(card_interrupt_request, 1'b0, "interrupt idle");
      $display("test done: status line");
      complete_run;
   end
   initial begin
      #100000;
      bad_count++;
      complete_run;
   end
endmodule
